/* File: core/crc32_word_accumulator.sv */
// CRC-32 word accumulator with scratch byte and reload control.
`timescale 1ns/1ps
`default_nettype none
`include "crc_params.svh"

module crc32_word_accumulator
  import crc_pkg::*;
#(
  parameter int AW        = 8,
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset
  input  wire logic          CORE_CLK,
  input  wire logic          RST,
  // Register port
  input  wire logic [AW-1:0] ADDR,
  input  wire logic [31:0]   WDATA,
  input  wire logic          WR,
  input  wire logic          RD,
  output logic      [31:0]   RDATA,
  // Flow control and status
  output logic               WR_READY,
  output logic               BUSY
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  acc_state_t  s_q;
  acc_state_t  s_d;

  logic        sel_result;
  logic        sel_scratch;
  logic        sel_control;
  logic        wr_result;
  logic        buf_in_ready;
  logic        buf_push;
  logic        buf_valid;
  logic        buf_pop;
  logic [31:0] buf_data;
  logic        take;
  logic        fold_last;
  logic        reload_exec;
  logic [31:0] step_in;
  logic [7:0]  step_byte;
  logic [31:0] step_out;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  assign sel_result  = (ADDR == AW'(`OFS_RESULT));
  assign sel_scratch = (ADDR == AW'(`OFS_SCRATCH));
  assign sel_control = (ADDR == AW'(`OFS_CONTROL));
  assign wr_result   = WR && sel_result;

  // --------------------------------------------------------------------
  // Input buffer
  // --------------------------------------------------------------------
  // New words are refused while a reload waits, so a word written after
  // the reload can never be folded into the value before it.
  assign WR_READY = buf_in_ready && !s_q.reload;
  assign buf_push = wr_result && WR_READY;

  word_skid_fifo #(
    .W     (32),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk       (CORE_CLK),
    .rst       (RST),
    .in_valid  (buf_push),
    .in_ready  (buf_in_ready),
    .in_data   (WDATA),
    .out_valid (buf_valid),
    .out_ready (buf_pop),
    .out_data  (buf_data)
  );

  // --------------------------------------------------------------------
  // Engine control terms
  // --------------------------------------------------------------------
  // The engine only takes a word when idle, which stalls the buffer and,
  // once it is full, the bus while an update runs.
  assign take        = (s_q.st == ENG_IDLE) && buf_valid;
  assign buf_pop     = take;
  assign fold_last   = (s_q.st == ENG_FOLD) && (s_q.step == `LAST_STEP);
  // Reload waits until queued words are folded, keeping write order.
  assign reload_exec = (s_q.st == ENG_IDLE) && !buf_valid && s_q.reload;
  assign BUSY        = (s_q.st == ENG_FOLD) || buf_valid;
  assign RDATA       = s_q.rdata;

  // --------------------------------------------------------------------
  // Byte folding datapath
  // --------------------------------------------------------------------
  // The first byte folds on the take edge from the stored result, so a
  // word completes in four edges instead of five.
  assign step_in   = (s_q.st == ENG_IDLE) ? s_q.crc : s_q.work;
  assign step_byte = (s_q.st == ENG_IDLE) ? buf_data[31:24]
                                          : s_q.word[31:24];

  crc_byte_step u_step (
    .crc_in  (step_in),
    .byte_in (step_byte),
    .crc_out (step_out)
  );

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    s_d       = s_q;
    s_d.rdata = 32'h00000000;

    case (s_q.st)
      ENG_IDLE: begin
        if (take) begin
          s_d.work = step_out;
          s_d.word = {buf_data[23:0], 8'h00};
          s_d.step = 2'h1;
          s_d.st   = ENG_FOLD;
        end else if (reload_exec) begin
          s_d.crc    = `CRC_INIT;
          s_d.reload = 1'b0;
        end
      end
      ENG_FOLD: begin
        s_d.work = step_out;
        s_d.word = {s_q.word[23:0], 8'h00};
        s_d.step = 2'(s_q.step + 1'b1);
        if (fold_last) begin
          // Result changes only here or on a reload; a read mid-update sees the old one.
          s_d.crc = step_out;
          s_d.st  = ENG_IDLE;
        end
      end
      default: begin
        s_d.st = ENG_IDLE;
      end
    endcase

    // Software sets after the hardware clear, so the set wins.
    if (WR && sel_control && WDATA[`CTRL_RELOAD_BIT]) begin
      s_d.reload = 1'b1;
    end

    // The scratch byte has no path into the datapath or reload.
    if (WR && sel_scratch) begin
      s_d.scratch = WDATA[7:0];
    end

    if (RD) begin
      if (sel_result) begin
        s_d.rdata = s_q.crc;
      end else if (sel_scratch) begin
        s_d.rdata = {24'h000000, s_q.scratch};
      end else if (sel_control) begin
        s_d.rdata[`CTRL_RELOAD_BIT] = s_q.reload;
        s_d.rdata[`CTRL_BUSY_BIT]   = BUSY;
      end else begin
        s_d.rdata = 32'h00000000;
      end
    end
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      s_q         <= '0;
      s_q.st      <= ENG_IDLE;
      s_q.crc     <= `CRC_INIT;
      s_q.scratch <= `SCRATCH_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------
  // Checking helpers
  // --------------------------------------------------------------------
  // Whole-word reference, bit serial, used only by the checks below.
  function automatic logic [31:0] crc_word_ref(
    input logic [31:0] crc,
    input logic [31:0] word
  );
    logic [31:0] c;
    c = crc;
    for (int b = 31; b >= 0; b--) begin
      c = {c[30:0], 1'b0} ^ ((c[31] ^ word[b]) ? `CRC_POLY : 32'h0);
    end
    return c;
  endfunction : crc_word_ref

  // Single-byte reference, used by the byte-step check below.
  function automatic logic [31:0] crc_byte_ref(
    input logic [31:0] crc,
    input logic [7:0]  data
  );
    logic [31:0] c;
    c = crc;
    for (int b = 7; b >= 0; b--) begin
      c = {c[30:0], 1'b0} ^ ((c[31] ^ data[b]) ? `CRC_POLY : 32'h0);
    end
    return c;
  endfunction : crc_byte_ref

  logic [31:0] ref_next;
  logic [4:0]  reload_wait;

  assign ref_next = crc_word_ref(s_q.crc, buf_data);

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      reload_wait <= 5'h00;
    end else if (!s_q.reload) begin
      reload_wait <= 5'h00;
    end else if (reload_wait != 5'h1F) begin
      reload_wait <= 5'(reload_wait + 1'b1);
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  a_reset_value: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    $fell(RST) |-> (s_q.crc == 32'hFFFFFFFF)
  ) else $error("Result is not all ones after reset.");

  a_update_four_cycles: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    take |=> (s_q.st == ENG_FOLD) [*3] ##1 (s_q.st == ENG_IDLE)
  ) else $error("Word update did not take four cycles.");

  a_fold_matches_ref: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    take |-> ##4 (s_q.crc == $past(ref_next, 4))
  ) else $error("Accumulated CRC does not match the reference.");

  // A lone one in the last bit reaches the top of the register only on
  // the final shift when bits enter most significant first.
  a_poly_msb_first: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (take && s_q.crc == 32'h00000000 && buf_data == 32'h00000001)
      |-> ##4 (s_q.crc == 32'h04C11DB7)
  ) else $error("Polynomial or bit order is wrong.");

  a_poly_fixed: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (take && s_q.crc == 32'h00000000 && buf_data[31:24] == 8'h01)
      |=> (s_q.work == 32'h04C11DB7)
  ) else $error("First byte fold does not use the fixed polynomial.");

  // Nothing may leave a full buffer while a fold runs, so the bus stays
  // stalled until the engine is free again.
  a_stall_writes: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (s_q.st == ENG_FOLD && !buf_in_ready) |=> !WR_READY
  ) else $error("Write accepted while buffer full and busy.");

  a_read_result: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (RD && sel_result) |=> (RDATA == $past(s_q.crc))
  ) else $error("Result read did not return the accumulated CRC.");

  a_reload_exec: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (reload_exec && !(WR && sel_control)) |=>
      (s_q.crc == 32'hFFFFFFFF) && !s_q.reload
  ) else $error("Reload did not set all ones and clear its bit.");

  a_reload_clears: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    s_q.reload |-> (reload_wait < 5'h0E)
  ) else $error("Reload bit was not cleared in time.");

  a_scratch_kept: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (reload_exec && !(WR && sel_scratch)) |=> $stable(s_q.scratch)
  ) else $error("Scratch byte changed on reload.");

  a_scratch_write: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (WR && sel_scratch) |=> (s_q.scratch == $past(WDATA[7:0]))
  ) else $error("Scratch byte does not hold the written value.");

  a_result_sources: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    $changed(s_q.crc) |-> $past(fold_last || reload_exec)
  ) else $error("Result changed without a fold or a reload.");

  // --------------------------------------------------------------------
  // Assertions on bus timing, engine steps, reload order and the scratch byte
  // --------------------------------------------------------------------
  a_ready_reset: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    $fell(RST) |-> (WR_READY && !BUSY)
  ) else $error("Port is not ready and idle after reset.");

  // Read data must drop back to zero so stale words never linger.
  a_rdata_zero: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    !RD |=> (RDATA == 32'h00000000)
  ) else $error("Read data did not return to zero.");

  a_write_accepted: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (wr_result && WR_READY) |=> BUSY
  ) else $error("Accepted word is neither queued nor folding.");

  a_engine_steps: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (s_q.st == ENG_FOLD && !fold_last) |=>
      (s_q.st == ENG_FOLD) && (s_q.step == 2'($past(s_q.step) + 2'h1))
  ) else $error("Fold step did not advance by one.");

  a_crc_held_mid: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (s_q.st == ENG_FOLD && !fold_last) |=> $stable(s_q.crc)
  ) else $error("Result moved in the middle of an update.");

  // Each edge of a fold takes one byte; a byte-level reference catches a
  // wrong tap in any of the eight unrolled bit stages.
  a_byte_fold: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (take || s_q.st == ENG_FOLD) |=>
      (s_q.work == crc_byte_ref($past(step_in), $past(step_byte)))
  ) else $error("Byte fold does not match the reference.");

  a_reload_set: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (WR && sel_control && WDATA[`CTRL_RELOAD_BIT]) |=> s_q.reload
  ) else $error("Writing one did not request a reload.");

  a_reload_waits: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (s_q.reload && (buf_valid || s_q.st == ENG_FOLD)) |=> s_q.reload
  ) else $error("Reload ran ahead of queued words.");

  a_scratch_hold: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    !(WR && sel_scratch) |=> $stable(s_q.scratch)
  ) else $error("Scratch byte changed without a write.");

  a_scratch_upper: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (RD && sel_scratch) |=> (RDATA[31:8] == 24'h000000)
  ) else $error("Scratch read shows bits above the byte.");

endmodule : crc32_word_accumulator
`default_nettype wire

/* File: core/crc_byte_step.sv */
// One byte of CRC folding, most significant bit first.
`timescale 1ns/1ps
`default_nettype none
`include "crc_params.svh"

module crc_byte_step (
  // Running value and byte
  input  wire logic [31:0] crc_in,
  input  wire logic [7:0]  byte_in,
  // Folded value
  output logic      [31:0] crc_out
);

  logic [31:0] chain [0:8];

  assign chain[0] = crc_in;

  // --------------------------------------------------------------------
  // Bit chain
  // --------------------------------------------------------------------
  for (genvar i = 0; i < 8; i++) begin : g_bit
    // No reflection: byte bit 7 enters first.
    assign chain[i+1] = {chain[i][30:0], 1'b0} ^
                        ((chain[i][31] ^ byte_in[7-i]) ?
                         `CRC_POLY : 32'h00000000);
  end

  assign crc_out = chain[8];

endmodule : crc_byte_step
`default_nettype wire

/* File: core/word_skid_fifo.sv */
// Small FIFO that holds words between the bus and the CRC engine.
`timescale 1ns/1ps
`default_nettype none

module word_skid_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [PW:0]             cnt;
  } fifo_state_t;

  fifo_state_t s_q;
  fifo_state_t s_d;
  logic        push;
  logic        pop;

  assign in_ready  = (s_q.cnt != (PW+1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = s_q.mem[s_q.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = (s_q.wp == PW'(DEPTH - 1)) ? '0 : PW'(s_q.wp + 1'b1);
    end
    if (pop) begin
      s_d.rp = (s_q.rp == PW'(DEPTH - 1)) ? '0 : PW'(s_q.rp + 1'b1);
    end
    if (push && !pop) begin
      s_d.cnt = (PW+1)'(s_q.cnt + 1'b1);
    end else if (pop && !push) begin
      s_d.cnt = (PW+1)'(s_q.cnt - 1'b1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : word_skid_fifo
`default_nettype wire

/* File: pkg/crc_params.svh */
// Offsets, field positions, reset values and timing counts of the CRC unit.
//
// Notes on behaviour
// - Fixed CRC-32 generator polynomial 0x4C11DB7.
// - Each word update finishes in four cycles.
// - Words fold into running CRC since reload.
// - Further data writes stall once the buffer fills while update runs.
// - Write feeds word; read returns accumulated CRC.
// - Control bit 0 reloads result with ones.
// - Software writes one; hardware clears reload bit.
// - Scratch byte survives a CRC reload.
// - Scratch byte never feeds the CRC.
`ifndef CRC_PARAMS_SVH
`define CRC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OFS_RESULT      8'h00
`define OFS_SCRATCH     8'h04
`define OFS_CONTROL     8'h08

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define CTRL_RELOAD_BIT 0
`define CTRL_BUSY_BIT   1
`define CRC_POLY        32'h04C11DB7
`define CRC_INIT        32'hFFFFFFFF
`define SCRATCH_RST     8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define UPDATE_CYCLES   3'h4
`define LAST_STEP       2'h3

`endif

/* File: pkg/crc_pkg.sv */
// Types shared by the CRC accumulator modules.
`default_nettype none
package crc_pkg;

  // --------------------------------------------------------------------
  // Engine states
  // --------------------------------------------------------------------
  typedef enum logic [0:0] {
    ENG_IDLE = 1'b0,
    ENG_FOLD = 1'b1
  } eng_state_t;

  // --------------------------------------------------------------------
  // Whole state of the top module
  // --------------------------------------------------------------------
  typedef struct packed {
    eng_state_t  st;
    logic [1:0]  step;
    logic [31:0] crc;
    logic [31:0] work;
    logic [31:0] word;
    logic [7:0]  scratch;
    logic        reload;
    logic [31:0] rdata;
  } acc_state_t;

endpackage : crc_pkg
`default_nettype wire

/* File: sim/bus_master_model.sv */
// Bus master model that drives the register port of the CRC unit.
`timescale 1ns/1ps
`default_nettype none

module bus_master_model (
  // Clock
  input  wire logic        clk,
  // Register port
  output var  logic [7:0]  addr,
  output var  logic [31:0] wdata,
  output var  logic        wr,
  output var  logic        rd,
  input  wire logic [31:0] rdata,
  input  wire logic        wr_ready
);
  int stalls;

  initial begin
    addr   = 8'h00;
    wdata  = 32'h0;
    wr     = 1'b0;
    rd     = 1'b0;
    stalls = 0;
  end

  // ------------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------------
  // The write strobe is left up on return so that back-to-back writes never
  // assign it twice in one time step; a read drops its strobe before returning.
  // A stalled data write is retried until taken; the bench watchdog
  // bounds the wait.
  task automatic write(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    rd    <= 1'b0;
    @(posedge clk);
    while (a == 8'h00 && wr_ready !== 1'b1) begin
      stalls++;
      @(posedge clk);
    end
  endtask : write

  task automatic read(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    wr   <= 1'b0;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : read

  // Software only ever writes a one into the reload bit.
  task automatic reload();
    write(8'h08, 32'h1);
  endtask : reload

  task automatic idle();
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask : idle
endmodule : bus_master_model
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking testbench of the CRC word accumulator.
`timescale 1ns/1ps
`default_nettype none
`include "crc_params.svh"

module tb;
  import crc_pkg::*;

  localparam logic [31:0] POLY = 32'h04C11DB7;
  localparam logic [31:0] ONES = 32'hFFFFFFFF;

  logic        clk;
  logic        rst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        wr_ready;
  logic        busy;
  int          errors;
  int          num_checks;
  logic [31:0] words [5] = '{32'h0, ONES, 32'h80000001, 32'hA5A5A5A5,
                             32'h0F0F0F0F};

  crc32_word_accumulator #(.AW(8), .BUF_DEPTH(2)) crc32_word_accumulator_inst (
    .CORE_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .WR_READY(wr_ready), .BUSY(busy));

  bus_master_model bus_master_model_inst (
    .clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .wr_ready(wr_ready));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] fold(input logic [31:0] c,
                                       input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      c = {c[30:0], 1'b0} ^ ((c[31] ^ w[i]) ? POLY : 32'h0);
    end
    return c;
  endfunction : fold

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    bus_master_model_inst.write(a, d);
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus_master_model_inst.read(a, d);
    check(d, exp);
  endtask : rd_chk

  // Counts edges from the accepting write edge until busy is seen low.
  task automatic settle(output int n);
    n = 1;
    bus_master_model_inst.idle();
    while (busy !== 1'b0 && n < 60) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, busy}, 32'h0);
  endtask : settle

  task automatic conclude();
    $display("errors %0d num_checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  // ------------------------------------------------------------------
  // Clock and watchdog
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // The whole sequence needs well under two hundred cycles; this is ample margin.
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    conclude();
  end

  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    logic [31:0] exp;
    int          n;
    errors     = 0;
    num_checks = 0;
    rst        = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`OFS_RESULT, ONES);
    rd_chk(`OFS_SCRATCH, 32'h0);
    rd_chk(8'h0C, 32'h0);
    wr_reg(`OFS_SCRATCH, 32'hDEADBEA5);
    rd_chk(`OFS_SCRATCH, 32'h000000A5);
    wr_reg(`OFS_RESULT, 32'h12345678);
    settle(n);
    check(32'(n), 32'h5);
    exp = fold(ONES, 32'h12345678);
    rd_chk(`OFS_RESULT, exp);
    rd_chk(`OFS_SCRATCH, 32'h000000A5);
    // Back-to-back words overrun the two-entry buffer and must stall.
    foreach (words[i]) begin
      wr_reg(`OFS_RESULT, words[i]);
      exp = fold(exp, words[i]);
    end
    settle(n);
    rd_chk(`OFS_RESULT, exp);
    check({31'h0, bus_master_model_inst.stalls != 0}, 32'h1);
    wr_reg(`OFS_RESULT, 32'hCAFE0001);
    exp = fold(exp, 32'hCAFE0001);
    settle(n);
    rd_chk(`OFS_RESULT, exp);
    // Reload with words still queued: they fold first, then ones return.
    wr_reg(`OFS_RESULT, 32'h11111111);
    wr_reg(`OFS_RESULT, 32'h22222222);
    bus_master_model_inst.reload();
    rd_chk(`OFS_CONTROL, 32'h3);
    settle(n);
    bus_master_model_inst.idle();
    rd_chk(`OFS_RESULT, ONES);
    rd_chk(`OFS_CONTROL, 32'h0);
    rd_chk(`OFS_SCRATCH, 32'h000000A5);
    wr_reg(`OFS_RESULT, 32'h00000001);
    settle(n);
    rd_chk(`OFS_RESULT, fold(ONES, 32'h00000001));
    // Known answers: ones on ones clears the result, and a lone low bit
    // then leaves the bare polynomial.
    bus_master_model_inst.reload();
    settle(n);
    wr_reg(`OFS_RESULT, ONES);
    wr_reg(`OFS_RESULT, 32'h00000001);
    settle(n);
    rd_chk(`OFS_RESULT, POLY);
    wr_reg(`OFS_RESULT, POLY);
    wr_reg(`OFS_RESULT, 32'h01000000);
    settle(n);
    rd_chk(`OFS_RESULT, fold(32'h0, 32'h01000000));
    wr_reg(8'h0C, 32'h55);
    rd_chk(`OFS_SCRATCH, 32'h000000A5);
    bus_master_model_inst.idle();
    conclude();
  end
endmodule : tb
`default_nettype wire
